// >>> dv/adcr_checker.sv
// Port-level properties of the converter control block.
// Assumes a bind to adcr_control_regs in a single clock domain.
`timescale 1ns/1ns
module adcr_checker (
	input wire        aclk,
	input wire        aresetn,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire [31:0] s_axi_rdata,
	input wire        core_done,
	input wire        converter_enable,
	input wire        conv_busy,
	input wire        conv_start,
	input wire        conv_abort,
	input wire        conversion_done_flag,
	input wire [31:0] pos_mux_sel,
	input wire [15:0] neg_mux_sel,
	input wire        pos_ref_supply,
	input wire        pos_ref_pin,
	input wire        pos_ref_fixed
);
	// ********************************
	// Conversion, decode and read bus properties
	// ********************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// The steps of one conversion: start, accepted end, cleared bit.
	sequence s_go; $rose(conv_busy); endsequence
	sequence s_fin; core_done && conv_busy; endsequence
	sequence s_end; !conv_busy && conversion_done_flag; endsequence

	a_go_start: assert property (s_go |-> ##[0:1] conv_start)
		else $error("start pulse missing");
	a_done_clear: assert property (s_fin |=> s_end)
		else $error("completion not seen");
	a_off_idle: assert property (!converter_enable |=> !conv_busy)
		else $error("busy while disabled");
	a_off_mux: assert property (!converter_enable |=>
		(pos_mux_sel == 32'h0) && (neg_mux_sel == 16'h0))
		else $error("mux connected while disabled");
	a_pos_legal: assert property ($onehot0(pos_mux_sel) &&
		((pos_mux_sel & 32'h0CDF_C000) == 32'h0))
		else $error("bad positive select");
	a_neg_onehot: assert property ($onehot0(neg_mux_sel))
		else $error("bad negative select");
	a_ref_onehot: assert property ($onehot0(
		{pos_ref_supply, pos_ref_pin, pos_ref_fixed}))
		else $error("two references at once");
	a_abort_pulse: assert property ($fell(conv_busy) &&
		!$past(core_done) |-> ##[0:1] conv_abort)
		else $error("abort pulse missing");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
endmodule

// >>> dv/adcr_control_regs_tb.sv
// Self-checking bench of the converter control register block.
// Assumes the design, the core model and the checker are compiled.
`timescale 1ns/1ns
module adcr_control_regs_tb;
	// ********************************
	// Signals and instances
	// ********************************
	logic        aclk = 0, aresetn = 0, smp_sign = 0;
	logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, rnd;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0;
	logic [15:0] trig_in = 0, res, old;
	logic [11:0] smp_mag = 0;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire         s_axi_rvalid, core_done, core_sign, converter_enable;
	wire         conv_busy, conv_start, conv_abort, conversion_done_flag;
	wire         neg_ref_pin_sel, pos_ref_supply, pos_ref_pin;
	wire         pos_ref_fixed, conv_clk_rc_sel, conv_clk_tick;
	wire [1:0]   s_axi_bresp, s_axi_rresp;
	wire [31:0]  s_axi_rdata, pos_mux_sel;
	wire [15:0]  neg_mux_sel;
	wire [11:0]  core_mag;
	integer      fails = 0, n_checks = 0, cyc = 0, n_st = 0, seed = 19515;
	integer      i, j;
	logic [33:0] rq[$];
	logic [1:0]  bq[$];

	adcr_control_regs adcr_control_regs_inst (.aclk, .aresetn,
		.s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trig_in, .core_done,
		.core_sign, .core_mag, .converter_enable, .conv_busy, .conv_start,
		.conv_abort, .conversion_done_flag, .pos_mux_sel, .neg_mux_sel,
		.neg_ref_pin_sel, .pos_ref_supply, .pos_ref_pin, .pos_ref_fixed,
		.conv_clk_rc_sel, .conv_clk_tick);
	adcr_core_model adcr_core_model_inst (.aclk, .aresetn, .conv_start,
		.conv_abort, .converter_enable, .smp_sign, .smp_mag, .core_done,
		.core_sign, .core_mag);

	// Free-running 100 MHz clock.
	initial forever #5 aclk = ~aclk;

	// Counts cycles and start pulses; a hang ends the run.
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (conv_start) n_st <= n_st + 1;
		if (cyc == 20000) begin
			fails = fails + 1;
			summarize;
		end
	end

	// Takes the oldest note whenever a response is handed over.
	always @(negedge aclk) begin
		if (s_axi_rvalid && s_axi_rready) chk(rq.pop_front(),
			{s_axi_rresp, s_axi_rdata});
		if (s_axi_bvalid && s_axi_bready) chk(bq.pop_front(), s_axi_bresp);
	end

	// ********************************
	// Tasks
	// ********************************
	task chk(input [33:0] e, input [33:0] g);
		n_checks = n_checks + 1;
		if (g !== e) begin
			fails = fails + 1;
			$display("Error %0t: bus got %h want %h", $time, g, e);
		end
	endtask

	task chk_sig(input [31:0] g, input [31:0] e);
		n_checks = n_checks + 1;
		if (g !== e) begin
			fails = fails + 1;
			$display("Error %0t: port got %h want %h", $time, g, e);
		end
	endtask

	task wr(input [7:0] a, input [7:0] d, input [1:0] r);
		logic ta, tw, da, dw;
		bq.push_back(r);
		da = 0;
		dw = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		while (!(da && dw)) begin
			@(negedge aclk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			da = da | ta;
			dw = dw | tw;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 0;
			if (tw) s_axi_wvalid <= 0;
		end
		do begin
			@(negedge aclk);
			ta = s_axi_bvalid;
			@(posedge aclk);
		end while (!ta);
		// Ready follows the answer, so a held answer is exercised.
		s_axi_bready <= 1;
		@(posedge aclk);
		s_axi_bready <= 0;
	endtask

	task rd(input [7:0] a, input [7:0] d, input [1:0] r);
		logic ta, tr;
		rq.push_back({r, 24'h0, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		do begin
			@(negedge aclk);
			ta = s_axi_arvalid && s_axi_arready;
			tr = s_axi_rvalid;
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 0;
		end while (!tr);
		s_axi_rready <= 1;
		@(posedge aclk);
		s_axi_rready <= 0;
	endtask

	function [15:0] fmt(input rmd, input fm, input s, input [11:0] m);
		logic [15:0] t;
		t = s ? -{4'h0, m} : {4'h0, m};
		if (fm) fmt = rmd ? {{2{t[15]}}, t[15:2]} : t;
		else fmt = rmd ? {m[11:2], 5'h0, s} : {m, 3'h0, s};
	endfunction

	// One software-started conversion with a random sample.
	task conv(input [7:0] c0, input [7:0] c1);
		rnd = $random(seed);
		smp_sign <= rnd[12];
		smp_mag <= rnd[11:0] | 12'h1;
		res = fmt(c0[7], c1[7], rnd[12], rnd[11:0] | 12'h1);
		wr(8'h04, c1, 2'h0);
		wr(8'h00, c0, 2'h0);
		wr(8'h00, c0 | 8'h02, 2'h0);
		rd(8'h00, c0 | 8'h02, 2'h0);
		rd(8'h0C, 8'h00, 2'h0);
		do @(negedge aclk); while (!conversion_done_flag);
		@(posedge aclk);
		rd(8'h00, c0, 2'h0);
		rd(8'h0C, res[15:8], 2'h0);
		rd(8'h10, res[7:0], 2'h0);
	endtask

	task summarize;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// ********************************
	// Main sequence
	// ********************************
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		for (i = 0; i < 32; i++) begin
			wr(8'h00, {1'h0, i[4:0], 2'h1}, 2'h0);
			wr(8'h08, {4'h0, i[3:0]}, 2'h0);
			@(negedge aclk);
			chk_sig(pos_mux_sel, (i <= 13 || i == 21 || i == 24 || i == 25
				|| i >= 28) ? 32'h1 << i : 32'h0);
			chk_sig(neg_mux_sel, 32'h1 << i[3:0]);
			chk_sig(converter_enable, 32'h1);
			@(posedge aclk);
		end
		for (i = 0; i < 8; i++) begin
			rnd = $random(seed);
			rnd[6:4] = i[2:0];
			rnd[1:0] = i[1:0];
			wr(8'h04, rnd[7:0], 2'h0);
			rd(8'h04, rnd[7:0] & 8'hF7, 2'h0);
			@(negedge aclk);
			chk_sig(neg_ref_pin_sel, rnd[2]);
			chk_sig({pos_ref_fixed, pos_ref_pin, pos_ref_supply},
				{rnd[1:0] == 3, rnd[1:0] == 1, rnd[1:0] == 0});
			chk_sig(conv_clk_rc_sel, rnd[5:4] == 2'h3);
			if (rnd[5:4] != 2'h3) begin
				do @(negedge aclk); while (!conv_clk_tick);
				j = 0;
				do begin
					@(negedge aclk);
					j = j + 1;
				end while (!conv_clk_tick);
				chk_sig(j, 2 << (rnd[6] + 2 * rnd[5:4]));
			end
			@(posedge aclk);
		end
		for (i = 0; i < 4; i++) conv({i[1], 5'h03, 2'h1}, {i[0], 7'h0});
		old = res;
		wr(8'h00, 8'h0D, 2'h0);
		wr(8'h00, 8'h0F, 2'h0);
		wr(8'h00, 8'h0D, 2'h0);
		repeat (40) @(posedge aclk);
		rd(8'h0C, old[15:8], 2'h0);
		rd(8'h10, old[7:0], 2'h0);
		for (i = 0; i < 16; i++) begin
			wr(8'h08, {i[3:0], 4'hF}, 2'h0);
			j = n_st;
			rnd = $random(seed);
			trig_in <= rnd[15:0] | (16'h1 << i);
			repeat (20) @(posedge aclk);
			trig_in <= 16'h0;
			repeat (50) @(posedge aclk);
			chk_sig(n_st - j, (i == 1 || i == 2 || (i >= 4 && i <= 9)
				|| i >= 13) ? 1 : 0);
		end
		// The last triggered conversion replaced the result bytes.
		old = fmt(1'b0, 1'b1, smp_sign, smp_mag);
		wr(8'h04, 8'hF7, 2'h0);
		wr(8'h14, 8'h55, 2'h2);
		aresetn <= 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		for (i = 0; i < 3; i++) rd(8'h04 * i, 8'h00, 2'h0);
		rd(8'h0C, old[15:8], 2'h0);
		rd(8'h14, 8'h00, 2'h2);
		summarize;
	end
endmodule

bind adcr_control_regs adcr_checker adcr_checker_inst (.aclk, .aresetn,
	.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .core_done,
	.converter_enable, .conv_busy, .conv_start, .conv_abort,
	.conversion_done_flag, .pos_mux_sel, .neg_mux_sel, .pos_ref_supply,
	.pos_ref_pin, .pos_ref_fixed);

// >>> dv/adcr_core_model.sv
// Stand-in for the converter core behind the control block.
// Assumes start and abort pulses from the control block on aclk.
`timescale 1ns/1ns
module adcr_core_model #(
	parameter LAT = 30
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire        conv_start,
	input  wire        conv_abort,
	input  wire        converter_enable,
	input  wire        smp_sign,
	input  wire [11:0] smp_mag,
	output reg         core_done,
	output reg         core_sign,
	output reg  [11:0] core_mag
);
	// ********************************
	// Conversion timer
	// ********************************
	integer cnt_reg;

	// Answers a start after LAT cycles; result lines toggle when idle.
	always @(posedge aclk) begin
		core_done <= 1'h0;
		core_sign <= ~core_sign;
		core_mag <= ~core_mag;
		if (!aresetn || conv_abort || !converter_enable) begin
			cnt_reg <= 0;
			core_sign <= 1'h0;
			core_mag <= 12'h5A5;
		end else if (conv_start) begin
			cnt_reg <= LAT;
		end else if (cnt_reg == 1) begin
			cnt_reg <= 0;
			core_done <= 1'h1;
			core_sign <= smp_sign;
			core_mag <= smp_mag;
		end else if (cnt_reg > 1) begin
			cnt_reg <= cnt_reg - 1;
		end
	end
endmodule

// >>> verilog/adcr_control_regs.v
// Control and status registers of a differential converter.
// Assumes an AXI4-Lite master, a converter core on aclk, and
// asynchronous trigger event inputs.
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "adcr_defines.vh"

// Functional notes
// - Width bit 1 gives 10-bit result bytes, 0 gives 12-bit.
// - Positive codes 0-13 pick inputs 0-13, 21 input 21.
// - Codes 31,30,29,28,25,24 pick internal sources; 27,26 none.
// - Writing 1 to status bit with enable bit 1 starts conversion; reads 1 meanwhile.
// - Hardware clears status bit when conversion finishes.
// - Enable bit 1 powers converter; 0 disables it.
// - Format bit 1 gives two's complement, 0 sign-magnitude.
// - Clock field picks divide 2,8,32,4,16,64 or the RC oscillator.
// - Negative reference bit 1 picks pin, 0 picks ground.
// - Positive reference: 00 supply, 01 pin, 11 fixed reference.
// - Trigger 0000 and 0011 disabled; 0001, 0010 capture units.
// - Trigger codes 0100-1001, 1101-1111 pick PWM unit events.
// - Negative codes 0-13 inputs, 1110 input 21, 1111 reference.
// - Enable 0 disconnects every multiplexer input.
// - Sign-magnitude high byte holds magnitude bits 11 to 4.
// - Control bits reset to 0; result bytes keep their value.
// - Rising edge of chosen trigger sets the status bit.
// - Start clears results; completion clears bit, raises flag.
// - Software abort discards result and keeps previous bytes.
module adcr_control_regs #(
	parameter ADDR_W = 8
) (
	input  wire              aclk,
	input  wire              aresetn,
	input  wire [ADDR_W-1:0] s_axi_awaddr,
	input  wire [2:0]        s_axi_awprot,
	input  wire              s_axi_awvalid,
	output wire              s_axi_awready,
	input  wire [31:0]       s_axi_wdata,
	input  wire [3:0]        s_axi_wstrb,
	input  wire              s_axi_wvalid,
	output wire              s_axi_wready,
	output reg  [1:0]        s_axi_bresp,
	output reg               s_axi_bvalid,
	input  wire              s_axi_bready,
	input  wire [ADDR_W-1:0] s_axi_araddr,
	input  wire [2:0]        s_axi_arprot,
	input  wire              s_axi_arvalid,
	output wire              s_axi_arready,
	output reg  [31:0]       s_axi_rdata,
	output reg  [1:0]        s_axi_rresp,
	output reg               s_axi_rvalid,
	input  wire              s_axi_rready,
	input  wire [15:0]       trig_in,
	input  wire              core_done,
	input  wire              core_sign,
	input  wire [11:0]       core_mag,
	output wire              converter_enable,
	output wire              conv_busy,
	output reg               conv_start,
	output reg               conv_abort,
	output reg               conversion_done_flag,
	output reg  [31:0]       pos_mux_sel,
	output reg  [15:0]       neg_mux_sel,
	output reg               neg_ref_pin_sel,
	output reg               pos_ref_supply,
	output reg               pos_ref_pin,
	output reg               pos_ref_fixed,
	output reg               conv_clk_rc_sel,
	output reg               conv_clk_tick
);

	// ****************************************************
	// Storage
	// ****************************************************
	reg  [7:0]        ctrl0_reg;
	reg  [7:0]        ctrl1_reg;
	reg  [7:0]        ctrl2_reg;
	reg  [7:0]        res_hi_reg;
	reg  [7:0]        res_lo_reg;
	reg  [7:0]        save_hi_reg;
	reg  [7:0]        save_lo_reg;
	reg               aw_hold_reg;
	reg               w_hold_reg;
	reg  [ADDR_W-1:0] waddr_reg;
	reg  [31:0]       wdata_reg;
	reg  [3:0]        wstrb_reg;
	reg  [5:0]        div_cnt_reg;
	reg  [5:0]        div_tc;
	reg               go_next;
	reg  [7:0]        fmt_hi;
	reg  [7:0]        fmt_lo;
	reg  [12:0]       twos;
	reg  [31:0]       rd_mux;
	reg               rd_hit;
	wire [15:0]       trig_edge;
	wire [15:0]       trig_ok;
	wire              do_write;
	wire              wr_lane0;
	wire [7:0]        wbyte;
	wire [ADDR_W-1:0] waddr_al;
	wire [ADDR_W-1:0] raddr_al;
	wire [4:0]        chs;
	wire [3:0]        chsn;
	wire [3:0]        trig_code;
	wire [2:0]        cs_code;
	wire              trig_hit;
	wire              sw_ctrl0;
	wire              go_done;

	assign chs       = ctrl0_reg[`ADCR_CHS_MSB:`ADCR_CHS_LSB];
	assign chsn      = ctrl2_reg[`ADCR_CHSN_MSB:`ADCR_CHSN_LSB];
	assign trig_code = ctrl2_reg[`ADCR_TRIG_MSB:`ADCR_TRIG_LSB];
	assign cs_code   = ctrl1_reg[`ADCR_CS_MSB:`ADCR_CS_LSB];
	assign converter_enable = ctrl0_reg[`ADCR_EN_BIT];
	assign conv_busy = ctrl0_reg[`ADCR_GO_BIT];

	// ****************************************************
	// AXI4-Lite write channel
	// ****************************************************
	// Address and data are taken independently, in either order.
	assign s_axi_awready = ~aw_hold_reg & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_hold_reg & ~s_axi_bvalid;
	assign do_write = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
	assign waddr_al = {waddr_reg[ADDR_W-1:2], 2'b00};
	assign wr_lane0 = do_write & wstrb_reg[0];
	assign wbyte    = wdata_reg[7:0];
	assign sw_ctrl0 = wr_lane0 & (waddr_al == `ADCR_OFF_CTRL0);

	// Capture halves of a write, then answer once both are in.
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_reg  <= 1'b0;
			w_hold_reg   <= 1'b0;
			waddr_reg    <= {ADDR_W{1'b0}};
			wdata_reg    <= 32'h0000_0000;
			wstrb_reg    <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `ADCR_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_reg <= 1'b1;
				waddr_reg   <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_hold_reg  <= 1'b0;
				w_hold_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (waddr_al > `ADCR_OFF_RES_LO)
					s_axi_bresp <= `ADCR_RESP_SLVERR;
				else
					s_axi_bresp <= `ADCR_RESP_OKAY;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ****************************************************
	// AXI4-Lite read channel
	// ****************************************************
	assign s_axi_arready = ~s_axi_rvalid;
	assign raddr_al = {s_axi_araddr[ADDR_W-1:2], 2'b00};

	// Read data select; reserved bits read as zero.
	always @* begin
		rd_hit = 1'b1;
		rd_mux = 32'h0000_0000;
		case (raddr_al)
		`ADCR_OFF_CTRL0:  rd_mux[7:0] = ctrl0_reg;
		`ADCR_OFF_CTRL1:  rd_mux[7:0] = ctrl1_reg;
		`ADCR_OFF_CTRL2:  rd_mux[7:0] = ctrl2_reg;
		`ADCR_OFF_RES_HI: rd_mux[7:0] = res_hi_reg;
		`ADCR_OFF_RES_LO: rd_mux[7:0] = res_lo_reg;
		default:          rd_hit = 1'b0;
		endcase
	end

	// One cycle from address taken to data valid.
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `ADCR_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_mux;
			if (rd_hit)
				s_axi_rresp <= `ADCR_RESP_OKAY;
			else
				s_axi_rresp <= `ADCR_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ****************************************************
	// Trigger selection
	// ****************************************************
	adcr_trig_edge #(
		.WIDTH(16)
	) adcr_trig_edge_inst (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.trig_in    (trig_in),
		.edge_pulse (trig_edge)
	);

	// Index by code; disabled and reserved codes are masked off.
	assign trig_ok  = `ADCR_TRIG_VALID;
	assign trig_hit = trig_edge[trig_code] & converter_enable
		& trig_ok[trig_code];

	// ****************************************************
	// Status bit sequencing
	// ****************************************************
	assign go_done = core_done & conv_busy;

	// Software set and clear, hardware clear, trigger set wins.
	// Turning the converter off beats a trigger, so busy never sticks.
	always @* begin
		go_next = conv_busy;
		if (sw_ctrl0)
			go_next = wbyte[`ADCR_GO_BIT] & wbyte[`ADCR_EN_BIT];
		if (go_done)
			go_next = 1'b0;
		if (trig_hit)
			go_next = 1'b1;
		if (sw_ctrl0 && !wbyte[`ADCR_EN_BIT])
			go_next = 1'b0;
	end

	// ****************************************************
	// Result formatting
	// ****************************************************
	// Negative zero magnitude encodes the most negative value.
	always @* begin
		if (core_sign && core_mag == 12'h000)
			twos = 13'h1000;
		else if (core_sign)
			twos = 13'h0000 - {1'b0, core_mag};
		else
			twos = {1'b0, core_mag};
		fmt_hi = core_mag[11:4];
		fmt_lo = {core_mag[3:0], 3'b000, core_sign};
		if (ctrl0_reg[`ADCR_RMD_BIT]) begin
			if (ctrl1_reg[`ADCR_FM_BIT]) begin
				fmt_hi = {{5{twos[12]}}, twos[12:10]};
				fmt_lo = twos[9:2];
			end else begin
				fmt_lo = {core_mag[3:2], 5'b00000, core_sign};
			end
		end else if (ctrl1_reg[`ADCR_FM_BIT]) begin
			fmt_hi = {{3{twos[12]}}, twos[12:8]};
			fmt_lo = twos[7:0];
		end
	end

	// ****************************************************
	// Control registers and handshake with the core
	// ****************************************************
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl0_reg            <= `ADCR_CTRL_RST;
			ctrl1_reg            <= `ADCR_CTRL_RST;
			ctrl2_reg            <= `ADCR_CTRL_RST;
			conv_start           <= 1'b0;
			conv_abort           <= 1'b0;
			conversion_done_flag <= 1'b0;
		end else begin
			if (sw_ctrl0)
				ctrl0_reg <= wbyte;
			ctrl0_reg[`ADCR_GO_BIT] <= go_next;
			if (wr_lane0 && waddr_al == `ADCR_OFF_CTRL1)
				ctrl1_reg <= wbyte & `ADCR_CTRL1_MASK;
			if (wr_lane0 && waddr_al == `ADCR_OFF_CTRL2)
				ctrl2_reg <= wbyte;
			conv_start <= go_next & ~conv_busy;
			conv_abort <= conv_busy & ~go_next & ~go_done;
			conversion_done_flag <= go_done;
		end
	end

	// Result bytes are not reset, so they survive a reset.
	always @(posedge aclk) begin
		if (go_next && !conv_busy) begin
			save_hi_reg <= res_hi_reg;
			save_lo_reg <= res_lo_reg;
			res_hi_reg  <= 8'h00;
			res_lo_reg  <= 8'h00;
		end else if (go_done) begin
			res_hi_reg <= fmt_hi;
			res_lo_reg <= fmt_lo;
		end else if (conv_busy && !go_next) begin
			res_hi_reg <= save_hi_reg;
			res_lo_reg <= save_lo_reg;
		end else if (wr_lane0) begin
			if (waddr_al == `ADCR_OFF_RES_HI)
				res_hi_reg <= wbyte;
			if (waddr_al == `ADCR_OFF_RES_LO)
				res_lo_reg <= wbyte;
		end
	end

	// ****************************************************
	// Conversion clock
	// ****************************************************
	// Terminal count for the selected system clock divider.
	always @* begin
		case (cs_code)
		`ADCR_CS_DIV2:  div_tc = `ADCR_TC_DIV2;
		`ADCR_CS_DIV8:  div_tc = `ADCR_TC_DIV8;
		`ADCR_CS_DIV32: div_tc = `ADCR_TC_DIV32;
		`ADCR_CS_DIV4:  div_tc = `ADCR_TC_DIV4;
		`ADCR_CS_DIV16: div_tc = `ADCR_TC_DIV16;
		`ADCR_CS_DIV64: div_tc = `ADCR_TC_DIV64;
		default:        div_tc = `ADCR_TC_DIV2;
		endcase
	end

	// Divider runs only while powered and not on the RC source.
	always @(posedge aclk) begin
		if (!aresetn) begin
			div_cnt_reg     <= 6'h00;
			conv_clk_tick   <= 1'b0;
			conv_clk_rc_sel <= 1'b0;
		end else begin
			conv_clk_rc_sel <= (cs_code[1:0] == `ADCR_CS_RC_LO);
			conv_clk_tick   <= 1'b0;
			if (!converter_enable || cs_code[1:0] == `ADCR_CS_RC_LO) begin
				div_cnt_reg <= 6'h00;
			end else if (div_cnt_reg >= div_tc) begin
				div_cnt_reg   <= 6'h00;
				conv_clk_tick <= 1'b1;
			end else begin
				div_cnt_reg <= div_cnt_reg + 6'h01;
			end
		end
	end

	// ****************************************************
	// Analog routing selects
	// ****************************************************
	// One-hot selects; the input multiplexers open while the converter is off.
	always @(posedge aclk) begin
		if (!aresetn) begin
			pos_mux_sel     <= 32'h0000_0000;
			neg_mux_sel     <= 16'h0000;
			neg_ref_pin_sel <= 1'b0;
			pos_ref_supply  <= 1'b0;
			pos_ref_pin     <= 1'b0;
			pos_ref_fixed   <= 1'b0;
		end else begin
			pos_mux_sel <= {31'h0000_0000, converter_enable} << chs
				& `ADCR_POS_VALID;
			neg_mux_sel <= {15'h0000, converter_enable}
				<< chsn;
			neg_ref_pin_sel <= ctrl1_reg[`ADCR_NREF_BIT];
			pos_ref_supply <= ctrl1_reg[`ADCR_PREF_MSB:`ADCR_PREF_LSB]
				== `ADCR_PREF_SUPPLY;
			pos_ref_pin <= ctrl1_reg[`ADCR_PREF_MSB:`ADCR_PREF_LSB]
				== `ADCR_PREF_PIN;
			pos_ref_fixed <= ctrl1_reg[`ADCR_PREF_MSB:`ADCR_PREF_LSB]
				== `ADCR_PREF_FIXED;
		end
	end

	// Protection bits carry no meaning for this block.
	wire unused_prot;
	assign unused_prot = ^{s_axi_awprot, s_axi_arprot, wdata_reg[31:8]};

endmodule

// >>> verilog/adcr_defines.vh
// Constants for the converter control register block.
// Assumes inclusion by bare name from the block's design files.
`ifndef ADCR_DEFINES_VH
`define ADCR_DEFINES_VH

// ****************************************************
// Register byte offsets
// ****************************************************
`define ADCR_OFF_CTRL0    8'h00
`define ADCR_OFF_CTRL1    8'h04
`define ADCR_OFF_CTRL2    8'h08
`define ADCR_OFF_RES_HI   8'h0C
`define ADCR_OFF_RES_LO   8'h10

// ****************************************************
// Field positions
// ****************************************************
`define ADCR_EN_BIT       0
`define ADCR_GO_BIT       1
`define ADCR_CHS_LSB      2
`define ADCR_CHS_MSB      6
`define ADCR_RMD_BIT      7
`define ADCR_PREF_LSB     0
`define ADCR_PREF_MSB     1
`define ADCR_NREF_BIT     2
`define ADCR_CS_LSB       4
`define ADCR_CS_MSB       6
`define ADCR_FM_BIT       7
`define ADCR_CHSN_LSB     0
`define ADCR_CHSN_MSB     3
`define ADCR_TRIG_LSB     4
`define ADCR_TRIG_MSB     7

// ****************************************************
// Reset values and masks
// ****************************************************
`define ADCR_CTRL_RST     8'h00
`define ADCR_CTRL1_MASK   8'hF7
`define ADCR_POS_VALID    32'hF320_3FFF
`define ADCR_TRIG_VALID   16'hE3F6

// ****************************************************
// Reference and clock codes
// ****************************************************
`define ADCR_PREF_SUPPLY  2'h0
`define ADCR_PREF_PIN     2'h1
`define ADCR_PREF_FIXED   2'h3
`define ADCR_CS_DIV2      3'h0
`define ADCR_CS_DIV8      3'h1
`define ADCR_CS_DIV32     3'h2
`define ADCR_CS_RC_A      3'h3
`define ADCR_CS_RC_LO     2'h3
`define ADCR_CS_DIV4      3'h4
`define ADCR_CS_DIV16     3'h5
`define ADCR_CS_DIV64     3'h6
`define ADCR_TC_DIV2      6'h01
`define ADCR_TC_DIV4      6'h03
`define ADCR_TC_DIV8      6'h07
`define ADCR_TC_DIV16     6'h0F
`define ADCR_TC_DIV32     6'h1F
`define ADCR_TC_DIV64     6'h3F

// ****************************************************
// Bus responses
// ****************************************************
`define ADCR_RESP_OKAY    2'h0
`define ADCR_RESP_SLVERR  2'h2

`endif

// >>> verilog/adcr_trig_edge.v
// Synchroniser and rising edge detector for trigger inputs.
// Assumes asynchronous inputs and a synchronous active-low reset.
`timescale 1ns/1ns

module adcr_trig_edge #(
	parameter WIDTH = 16
) (
	input  wire             aclk,
	input  wire             aresetn,
	input  wire [WIDTH-1:0] trig_in,
	output wire [WIDTH-1:0] edge_pulse
);

	// ****************************************************
	// Per-input synchroniser
	// ****************************************************
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			reg meta_reg;
			reg sync_reg;
			reg last_reg;

			// Two flops for the crossing, a third for history.
			always @(posedge aclk) begin
				if (!aresetn) begin
					meta_reg <= 1'b0;
					sync_reg <= 1'b0;
					last_reg <= 1'b0;
				end else begin
					meta_reg <= trig_in[i];
					sync_reg <= meta_reg;
					last_reg <= sync_reg;
				end
			end

			// One pulse per synchronised rising edge.
			assign edge_pulse[i] = sync_reg & ~last_reg;
		end
	endgenerate

endmodule
